// ### logic/tlb_map.svh
// constants for the memory-mapped translation buffer array access block
`ifndef TLB_MAP_SVH
`define TLB_MAP_SVH

// region codes in address bits 31-24
`define REGION_HI 31
`define REGION_LO 24
`define REGION_DATA 8'hF3
`define REGION_ADDR 8'hF2

// own control registers, full byte addresses
`define PAGE_HIGH_ADDR 32'hFF000000
`define XLATE_CTRL_ADDR 32'hFF000010

// field positions in the access address
`define INDEX_HI 16
`define INDEX_LO 12
`define WAY_HI 9
`define WAY_LO 8

// field positions in the data words
`define VALID_BIT 8
`define HASH_SEL_BIT 0
`define IDENT_HASH_HI 4
`define IDENT_HASH_LO 0

// storable bits of each word
`define DATA_WORD_MASK 32'h1FFFFDFE
`define TAG_WORD_MASK 32'hFFFE0CFF
`define PAGE_HIGH_MASK 32'hFFFFFCFF
`define XLATE_CTRL_MASK 32'h00000001

// reset values and the full write strobe
`define PAGE_HIGH_RESET 32'h00000000
`define XLATE_CTRL_RESET 32'h00000000
`define READ_DATA_RESET 32'h00000000
`define FULL_STROBE 4'hF

`endif

// ### logic/tlb_pkg.sv
// types shared by the translation buffer array access block
`default_nettype none
package tlb_pkg;
	// what a decoded bus address reaches
	typedef enum logic [2:0] {
		TGT_NONE,
		TGT_DATA,
		TGT_ADDR,
		TGT_PAGE_HIGH,
		TGT_XLATE_CTRL
	} target_e;

	typedef logic [4:0] index_t;
	typedef logic [1:0] way_t;
	typedef logic [6:0] slot_t;
	typedef logic [31:0] word_t;
endpackage
`default_nettype wire

// ### logic/tlb_mem_access.sv
// apb slave giving software access to the translation buffer arrays
//
// The APB interface to the registers and the address map were decided locally.
`include "tlb_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tlb_mem_access (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire tlb_pkg::word_t paddr_i,
	input wire tlb_pkg::word_t pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [2:0] pprot_i,
	output logic pready_o,
	output tlb_pkg::word_t prdata_o,
	output logic pslverr_o,
	// state seen by the translation logic
	output logic hash_select_o,
	output logic [7:0] address_space_identifier_o
);
	import tlb_pkg::*;

	// the address array sits at its own region code and shares the
	// valid bit with the data array; associative writes to it are
	// not supported, every write goes to the selected slot

	// one word per entry and way; 32 indices times four ways
	word_t data_mem [0:127];
	word_t tag_mem [0:127];
	// valid bit per slot, shared by both arrays
	logic [127:0] valid_reg;
	logic [127:0] valid_next;
	// control registers
	word_t page_high_reg;
	word_t page_high_next;
	word_t xlate_ctrl_reg;
	word_t xlate_ctrl_next;
	// read data flop
	word_t rdata_reg;
	word_t rdata_next;

	// decoded access
	target_e target;
	index_t index_sel;
	slot_t slot;
	// bus phase and qualification
	logic setup_phase;
	logic access_phase;
	logic privileged;
	logic full_word;
	logic access_ok;
	// write side of the arrays
	logic array_wr;
	logic data_wr;
	logic tag_wr;
	word_t wr_word;
	word_t data_word_next;
	word_t tag_word_next;
	// read side
	word_t read_word;

	// region decode; in the two array regions address bits outside the fields are don't care, the control registers match the full address
	function automatic target_e decode(input word_t addr);
		if (addr[`REGION_HI:`REGION_LO] == `REGION_DATA) begin
			decode = TGT_DATA;
		end else if (addr[`REGION_HI:`REGION_LO] == `REGION_ADDR) begin
			decode = TGT_ADDR;
		end else if (addr == `PAGE_HIGH_ADDR) begin
			decode = TGT_PAGE_HIGH;
		end else if (addr == `XLATE_CTRL_ADDR) begin
			decode = TGT_XLATE_CTRL;
		end else begin
			decode = TGT_NONE;
		end
	endfunction

	// entry index, optionally hashed with the space identifier
	function automatic index_t make_index(input index_t page,
			input index_t ident, input logic hash);
		make_index = hash ? (page ^ ident) : page;
	endfunction

	// address decode and slot selection
	always_comb begin
		target = decode(paddr_i);
		index_sel = make_index(paddr_i[`INDEX_HI:`INDEX_LO],
			page_high_reg[`IDENT_HASH_HI:`IDENT_HASH_LO],
			xlate_ctrl_reg[`HASH_SEL_BIT]);
		slot = {index_sel, paddr_i[`WAY_HI:`WAY_LO]};
	end

	// access qualification; pprot bit 0 marks a privileged master
	always_comb begin
		setup_phase = psel_i && !penable_i;
		access_phase = psel_i && penable_i;
		privileged = pprot_i[0];
		// reads carry no size, so only writes can be checked here
		full_word = !pwrite_i || (pstrb_i == `FULL_STROBE);
		access_ok = (target != TGT_NONE) && full_word
			&& (privileged || target == TGT_NONE);
		array_wr = access_phase && pwrite_i && access_ok
			&& (target == TGT_DATA || target == TGT_ADDR);
	end

	// read value of the selected word, valid bit shared by both arrays
	always_comb begin
		read_word = '0;
		unique case (target)
			TGT_DATA: begin
				read_word = data_mem[slot] & `DATA_WORD_MASK;
				read_word[`VALID_BIT] = valid_reg[slot];
			end
			TGT_ADDR: begin
				// index bits of the tag read back as zero
				read_word = tag_mem[slot] & `TAG_WORD_MASK;
				read_word[`VALID_BIT] = valid_reg[slot];
			end
			TGT_PAGE_HIGH: read_word = page_high_reg;
			TGT_XLATE_CTRL: read_word = xlate_ctrl_reg;
			TGT_NONE: read_word = '0;
		endcase
	end

	// write data and array write enables for the access edge
	always_comb begin
		wr_word = pwdata_i;
		data_wr = array_wr && (target == TGT_DATA);
		tag_wr = array_wr && (target == TGT_ADDR);
		// unused bits dropped on the way in so reads see zero
		data_word_next = wr_word & `DATA_WORD_MASK;
		tag_word_next = wr_word & `TAG_WORD_MASK;
	end

	// next value of the two control registers
	always_comb begin
		page_high_next = page_high_reg;
		xlate_ctrl_next = xlate_ctrl_reg;
		if (access_phase && pwrite_i && access_ok) begin
			if (target == TGT_PAGE_HIGH) begin
				page_high_next = wr_word & `PAGE_HIGH_MASK;
			end
			if (target == TGT_XLATE_CTRL) begin
				xlate_ctrl_next = wr_word & `XLATE_CTRL_MASK;
			end
		end
	end

	// next read data; captured in setup so the access sees a flop
	always_comb begin
		rdata_next = rdata_reg;
		if (setup_phase) begin
			// refused reads return zero rather than stale data
			rdata_next = access_ok ? read_word : '0;
		end
	end

	// next valid bits; both arrays share one bit per slot
	always_comb begin
		valid_next = valid_reg;
		if (array_wr) begin
			// zero here drops the entry at once
			valid_next[slot] = wr_word[`VALID_BIT];
		end
	end

	// control registers; reset turns hashing off, identifier zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			page_high_reg <= `PAGE_HIGH_RESET;
			xlate_ctrl_reg <= `XLATE_CTRL_RESET;
		end else begin
			page_high_reg <= page_high_next;
			xlate_ctrl_reg <= xlate_ctrl_next;
		end
	end

	// read data register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_reg <= `READ_DATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// valid bits; every entry starts invalid after reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			valid_reg <= '0;
		end else begin
			valid_reg <= valid_next;
		end
	end

	// array storage carries no reset: the valid bits guard it
	always_ff @(posedge clk_i) begin
		if (data_wr) begin
			data_mem[slot] <= data_word_next;
		end
		if (tag_wr) begin
			tag_mem[slot] <= tag_word_next;
		end
	end

	// zero wait states: every access phase ends after one cycle
	always_comb begin
		pready_o = 1'b1;
		// error only in the access phase, so an idle bus shows zero
		pslverr_o = access_phase && !access_ok;
		prdata_o = rdata_reg;
		hash_select_o = xlate_ctrl_reg[`HASH_SEL_BIT];
		address_space_identifier_o = page_high_reg[7:0];
	end
endmodule
`default_nettype wire

// ### sim/tlb_mem_access_checker.sv
// port assertions for the array access block
`include "tlb_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tlb_mem_access_checker (
	// watched ports
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire tlb_pkg::word_t paddr_i,
	input wire tlb_pkg::word_t pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [2:0] pprot_i,
	input wire logic pready_o,
	input wire tlb_pkg::word_t prdata_o,
	input wire logic pslverr_o,
	input wire logic hash_select_o,
	input wire logic [7:0] address_space_identifier_o
);
	import tlb_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ok marks a privileged full-word access phase
	wire acc = psel_i && penable_i;
	wire ok = acc && pprot_i[0] && pstrb_i == `FULL_STROBE;
	wire [7:0] rg = paddr_i[31:24];
	wire wc = ok && pwrite_i && paddr_i == `XLATE_CTRL_ADDR;
	wire wp = ok && pwrite_i && paddr_i == `PAGE_HIGH_ADDR;
	wire reg_a = paddr_i == `XLATE_CTRL_ADDR || paddr_i == `PAGE_HIGH_ADDR;
	property p_rdy; pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("ready low");
	property p_user; acc && !pprot_i[0] |-> pslverr_o; endproperty
	a_user: assert property (p_user) else $error("user taken");
	property p_strb;
		acc && pwrite_i && pstrb_i != `FULL_STROBE |-> pslverr_o;
	endproperty
	a_strb: assert property (p_strb) else $error("part word");
	property p_out;
		acc && rg != `REGION_DATA && rg != `REGION_ADDR && !reg_a |-> pslverr_o;
	endproperty
	a_out: assert property (p_out) else $error("outside taken");
	property p_data; ok && rg == `REGION_DATA |-> !pslverr_o; endproperty
	a_data: assert property (p_data) else $error("data refused");
	property p_addr; ok && rg == `REGION_ADDR |-> !pslverr_o; endproperty
	a_addr: assert property (p_addr) else $error("addr refused");
	property p_idle; !acc |-> !pslverr_o; endproperty
	a_idle: assert property (p_idle) else $error("stray error");
	property p_hash;
		wc |=> hash_select_o == $past(pwdata_i[0]);
	endproperty
	a_hash: assert property (p_hash) else $error("hash bit");
	property p_ident;
		wp |=> address_space_identifier_o == $past(pwdata_i[7:0]);
	endproperty
	a_ident: assert property (p_ident) else $error("identifier");
	c_hash: cover property (wc);
	c_err: cover property (acc && pslverr_o);
	c_read: cover property (ok && !pwrite_i && rg == `REGION_DATA);
endmodule
bind tlb_mem_access tlb_mem_access_checker chk (.*);
`default_nettype wire

// ### sim/core_model.sv
// apb master standing in for the core
`timescale 1ns/100ps
`default_nettype none
module core_model (
	// clock and answer
	input wire logic clk_i,
	input wire logic pready_i,
	// request
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output tlb_pkg::word_t paddr_o,
	output tlb_pkg::word_t pwdata_o,
	output logic [3:0] pstrb_o,
	output logic [2:0] pprot_o,
	output logic hung_o
);
	import tlb_pkg::*;
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
	initial {pstrb_o, pprot_o, hung_o} = '0;
	// setup, access held until ready; released lines invert
	task automatic xfer(input logic w, input word_t a, d,
			input logic [3:0] s, input logic [2:0] p);
		int n;
		@(posedge clk_i);
		// privilege level fixed for the whole transfer
		{psel_o, pwrite_o, paddr_o, pwdata_o, pstrb_o, pprot_o} <=
			{1'h1, w, a, d, s, p};
		@(posedge clk_i);
		penable_o <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_i);
			if (pready_i)
				break;
		end
		hung_o <= hung_o || n == 64;
		{psel_o, penable_o, paddr_o, pwdata_o} <= {2'h0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// ### sim/test_tlb_mem_access.sv
// self-checking bench for the array access block
`include "tlb_map.svh"
`timescale 1ns/100ps
`default_nettype none
module test_tlb_mem_access;
	import tlb_pkg::*;
	logic clk_i = 0, rstn_i = 0, pready_o, pslverr_o, hash_select_o, hung;
	logic psel_i, penable_i, pwrite_i;
	logic [3:0] pstrb_i;
	logic [2:0] pprot_i;
	logic [7:0] address_space_identifier_o;
	word_t paddr_i, pwdata_i, prdata_o, d[4], a;
	logic [32:0] q[$];
	int errors = 0, num_checks = 0;
	logic [4:0] ix, id;
	always #20 clk_i = ~clk_i;
	tlb_mem_access DUT (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .pprot_i, .pready_o, .prdata_o,
		.pslverr_o, .hash_select_o, .address_space_identifier_o);
	core_model core (.clk_i, .pready_i(pready_o), .psel_o(psel_i),
		.penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
		.pwdata_o(pwdata_i), .pstrb_o(pstrb_i), .pprot_o(pprot_i),
		.hung_o(hung));
	// each read answer against the oldest note
	always @(posedge clk_i)
		if (psel_i && penable_i && pready_o && !pwrite_i) begin
			num_checks++;
			if (q.size() == 0
				|| {pslverr_o, prdata_o} !== q.pop_front()) begin
				errors++;
				$display("Error %0t read %h", $time, paddr_i);
			end
		end
	task automatic wr(input word_t a, v, input logic [3:0] s = 4'hF,
			input logic [2:0] p = 3'h1);
		core.xfer(1'h1, a, v, s, p);
	endtask
	task automatic rd(input word_t a, v, input logic e = 1'h0,
			input logic [2:0] p = 3'h1);
		q.push_back({e, v});
		core.xfer(1'h0, a, ~v, 4'hF, p);
	endtask
	// don't-care address bits get noise on every data array access
	function automatic word_t da(input logic [4:0] i, input logic [1:0] w);
		return {`REGION_DATA, 7'($urandom), i, 2'($urandom), w, 8'($urandom)};
	endfunction
	initial begin
		void'($urandom(32'h5DE9));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'h1;
		ix = 5'($urandom);
		foreach (d[w]) begin
			d[w] = $urandom;
			wr(da(ix, 2'(w)), d[w]);
		end
		foreach (d[w])
			rd(da(ix, 2'(w)), d[w] & `DATA_WORD_MASK);
		$display("ways done");
		a = d[0] | 32'h100;
		wr(da(ix, 2'h0), a);
		rd(da(ix, 2'h0), a & `DATA_WORD_MASK);
		wr({`REGION_ADDR, 7'h0, ix, 12'h0}, '0);
		rd(da(ix, 2'h0), a & `DATA_WORD_MASK & ~32'h100);
		$display("invalidate done");
		id = 5'($urandom);
		wr(`PAGE_HIGH_ADDR, {27'h0, id});
		wr(`XLATE_CTRL_ADDR, 32'h1);
		wr(da(ix, 2'h1), d[2]);
		wr(`XLATE_CTRL_ADDR, 32'h0);
		rd(da(ix ^ id, 2'h1), d[2] & `DATA_WORD_MASK);
		rd(`PAGE_HIGH_ADDR, {27'h0, id});
		$display("hash done");
		wr(da(ix, 2'h2), ~d[2], 4'h3);
		wr(da(ix, 2'h2), ~d[2], 4'hF, 3'h0);
		rd(da(ix, 2'h2), 32'h0, 1'h1, 3'h0);
		rd(32'hF4000000, 32'h0, 1'h1);
		rd(da(ix, 2'h2), d[2] & `DATA_WORD_MASK);
		$display("refusals done");
		@(posedge clk_i);
		rstn_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		num_checks++;
		if (hash_select_o !== 1'h0
			|| address_space_identifier_o !== 8'h0) begin
			errors++;
			$display("Error %0t reset state", $time);
		end
		rstn_i <= 1'h1;
		rd(`PAGE_HIGH_ADDR, 32'h0);
		rd(da(ix, 2'h2), d[2] & `DATA_WORD_MASK & ~32'h100);
		$display("reset done");
		repeat (2) @(posedge clk_i);
		test_done();
	end
	task automatic test_done();
		if (hung || q.size() != 0) begin
			errors++;
			$display("Error %0t hang", $time);
		end
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
endmodule
`default_nettype wire
